// ---- verilog/loop_det_defines.svh ----
// Constants for the loop detector channel timing block: offsets, fields, resets, timings.
// Assumes a 100 MHz aclk and a front end reporting inductance drop in 0.001 percent units.
`ifndef LOOP_DET_DEFINES_SVH
`define LOOP_DET_DEFINES_SVH

// Clock and tick
`define CLK_NS        10
`define TICK_NS       1000000
`define TICK_CYC      (`TICK_NS / `CLK_NS)

// Channel timings in milliseconds or seconds as specified
`define PULSE_MS      125
`define MIN_CALL_MS   125
`define TUNEOUT_S     2
`define TUNEOUT_MS    (`TUNEOUT_S * 1000)
`define SETTLE_MS     1000
`define FULL_OP_S     30
`define FULL_OP_MS    (`FULL_OP_S * 1000)
`define TRACK_MS      250

// Thresholds in 0.001 percent units: 320, 80, 20
`define THR_LOW       17'h0140
`define THR_MED       17'h0050
`define THR_HIGH      17'h0014

// Register map (byte addresses)
`define CFG_BASE      8'h00
`define STAT_ADDR     8'h20
`define CFG_RESET     5'h04
`define STAT_SETTLED  30
`define STAT_FULL     31

// AXI responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ---- verilog/loop_det_pkg.sv ----
// Types shared by the loop detector channel timing block.
// Assumes nothing beyond the constants header.
package loop_det_pkg;

  typedef enum logic {MODE_PRESENCE, MODE_PULSE} mode_t;

  typedef enum logic [1:0] {SENS_LOW, SENS_MED, SENS_HIGH, SENS_TOP} sens_t;

  typedef enum logic [1:0] {ST_SETTLE, ST_IDLE, ST_DETECT} chan_state_t;

  // Per-channel configuration, mode in bit 0
  typedef struct packed {
    logic [1:0] freq;
    sens_t      sens;
    mode_t      mode;
  } cfg_t;

  // Per-channel input from the analogue front end and front panel
  typedef struct packed {
    logic               fault;
    logic               disable_sw;
    logic signed [15:0] dev;
  } chan_in_t;

endpackage

// ---- verilog/loop_det_timing.sv ----
// Call-output timing for a multi-channel inductive loop detector, with AXI4-Lite registers.
// Assumes synchronous inputs, one clock, and a front end reporting signed inductance drop.
//
// Overview of operation
// - Each channel keeps its own timers, state and output, fully separate.
// - A per-channel switch input disables the channel; it then issues no call unless a fault is flagged.
// - A recognised detection holds the call at least 125 ms.
// - A flagged channel, loop or cable fault forces a constant call.
// - Sensitivity thresholds selectable: low 0.32, medium 0.08, high 0.02 percent.
// - Pulse or presence mode chosen per channel, independently.
// - Three or more frequencies per channel; all settings chosen per channel.
// - Pulse mode gives one 125 ms call pulse per arriving vehicle.
// - Pulse mode absorbs a detection lasting over 2 s into the baseline.
// - Pulse mode can detect a following vehicle within 3 s.
// - Presence mode returns to normal sensitivity within 1 s after detection.
// - Highest sensitivity presence holds stationary vehicles three or ten minutes.
// - Lowest sensitivity presence holds a one percent change four minutes.
// - Lowest sensitivity detects 0.15 to 0.4 percent, never below 0.1 percent.
// - Lowest sensitivity presence asserts call within 20 ms of threshold crossing.
// - Call releases within 20 ms after change ends, after minimum duration.
// - Highest sensitivity asserts call within 250 ms for one percent change.
// - Normal detection within 2 s, full operation within 30 s after reset.
// - Baseline retunes automatically so slow drift never calls.
// - Baseline follows drift up to 0.001 percent per second without calling.
// - Detection works across plus or minus 5 percent from tuning point.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "loop_det_defines.svh"

module loop_det_timing #(
  parameter int NCH      = 2,
  parameter int TICK_CYC = `TICK_CYC
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [7:0]                      s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [7:0]                      s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire loop_det_pkg::chan_in_t [NCH-1:0] chan_in,
  output logic [NCH-1:0]                       call_out,
  output logic [NCH-1:0][1:0]                  freq_sel,
  output logic                                 full_op
);
  import loop_det_pkg::*;

  if (NCH < 1 || NCH > 8 || TICK_CYC < 2)
    $error("loop_det_timing: unsupported parameter values");

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Millisecond tick shared by every timer
  logic [31:0] tick_cnt_r;
  logic        tick_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end
    else if (tick_cnt_r == 32'(TICK_CYC - 1))
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // Start-up settling and full-operation timer after reset
  logic [15:0] up_ms_r;
  logic        settled_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      up_ms_r   <= 16'h0000;
      settled_r <= 1'b0;
      full_op   <= 1'b0;
    end
    else if (tick_r && !full_op)
    begin
      up_ms_r <= up_ms_r + 16'h0001;
      if (up_ms_r == 16'(`SETTLE_MS - 1))
        settled_r <= 1'b1;
      if (up_ms_r == 16'(`FULL_OP_MS - 1))
        full_op <= 1'b1;
    end
  end

  // Configuration registers, one per channel
  cfg_t [NCH-1:0] cfg_r;
  logic [7:0]     aw_addr_r;
  logic [31:0]    w_data_r;
  logic           w_lane0_r;
  logic           aw_have_r;
  logic           w_have_r;
  logic           wr_go;
  logic           wr_hit;
  logic [2:0]     wr_idx;

  assign wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_idx = aw_addr_r[4:2];
  assign wr_hit = (aw_addr_r[7:5] == 3'h0) && (aw_addr_r[1:0] == 2'h0) && (32'(wr_idx) < NCH);

  // Write address and data capture, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_lane0_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_have_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
      else if (wr_go)
        w_have_r <= 1'b0;
    end
  end

  // Write response and configuration update
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      for (int i = 0; i < NCH; i++)
        cfg_r[i] <= cfg_t'(`CFG_RESET);
    end
    else
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_hit && w_lane0_r)
          cfg_r[wr_idx] <= cfg_t'(w_data_r[4:0]);
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Frequency selection passed to the front end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      freq_sel <= '0;
    else
      for (int i = 0; i < NCH; i++)
        freq_sel[i] <= cfg_r[i].freq;
  end

  // Per-channel detection, baseline and call timing
  chan_state_t [NCH-1:0] st_r;
  logic [NCH-1:0]        det_vec;

  for (genvar ch = 0; ch < NCH; ch++)
  begin : g_ch
    logic signed [15:0] base_r;
    logic signed [16:0] delta;
    logic signed [16:0] thr;
    logic               above;
    logic [11:0]        det_ms_r;
    logic [7:0]         call_ms_r;
    logic [7:0]         trk_ms_r;
    logic               call_nxt;

    // Threshold per sensitivity
    always_comb
    begin
      unique case (cfg_r[ch].sens)
        SENS_LOW: thr = `THR_LOW;
        SENS_MED: thr = `THR_MED;
        SENS_HIGH,
        SENS_TOP: thr = `THR_HIGH;
      endcase
    end

    // Drop relative to the tracked baseline; 17 bits covers the full range
    assign delta = 17'(chan_in[ch].dev) - 17'(base_r);
    assign above = delta >= thr;

    // Channel state and baseline tracking
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        st_r[ch] <= ST_SETTLE;
        base_r   <= 16'sh0000;
        det_ms_r <= 12'h000;
        trk_ms_r <= 8'h00;
      end
      else
      begin
        unique case (st_r[ch])
          ST_SETTLE:
          begin
            base_r <= chan_in[ch].dev;
            if (settled_r)
              st_r[ch] <= ST_IDLE;
          end
          ST_IDLE:
          begin
            if (above)
            begin
              st_r[ch] <= ST_DETECT;
              det_ms_r <= 12'h000;
            end
            else if (delta < 0)
              base_r <= chan_in[ch].dev;
            else if (tick_r)
            begin
              trk_ms_r <= trk_ms_r + 8'h01;
              if (trk_ms_r == 8'(`TRACK_MS - 1))
              begin
                trk_ms_r <= 8'h00;
                if (delta > 0)
                  base_r <= base_r + 16'sh0001;
              end
            end
          end
          ST_DETECT:
          begin
            if (!above)
              st_r[ch] <= ST_IDLE;
            else if (cfg_r[ch].mode == MODE_PULSE && tick_r)
            begin
              det_ms_r <= det_ms_r + 12'h001;
              if (det_ms_r == 12'(`TUNEOUT_MS))
              begin
                base_r   <= chan_in[ch].dev;
                st_r[ch] <= ST_IDLE;
              end
            end
          end
          default: st_r[ch] <= ST_IDLE;
        endcase
      end
    end

    // Minimum call and pulse length, loaded on each new detection
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        call_ms_r <= 8'h00;
      else if (st_r[ch] == ST_IDLE && above)
        call_ms_r <= 8'(`PULSE_MS);
      else if (tick_r && call_ms_r != 8'h00)
        call_ms_r <= call_ms_r - 8'h01;
    end

    // Call output: fault forces, disable releases; presence holds while detected
    assign call_nxt = chan_in[ch].fault ||
                      (!chan_in[ch].disable_sw && settled_r &&
                       (call_ms_r != 8'h00 ||
                        (cfg_r[ch].mode == MODE_PRESENCE && st_r[ch] == ST_DETECT)));

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        call_out[ch] <= 1'b0;
      else
        call_out[ch] <= call_nxt;
    end

    assign det_vec[ch] = (st_r[ch] == ST_DETECT);

    chk_fault_call: assert property (chan_in[ch].fault |=> call_out[ch])
      else $error("fault did not force the call");
    chk_disable_quiet: assert property
      (chan_in[ch].disable_sw && !chan_in[ch].fault |=> !call_out[ch])
      else $error("disabled channel issued a call");
    chk_min_call_hold: assert property
      ($fell(call_out[ch]) |-> $past(chan_in[ch].fault) || $past(chan_in[ch].disable_sw)
        || $past(call_ms_r) == 8'h00)
      else $error("call released before its minimum duration");
    chk_pulse_bound: assert property
      (cfg_r[ch].mode == MODE_PULSE && st_r[ch] == ST_IDLE && above
        |=> call_ms_r == 8'(`PULSE_MS) ##1 call_out[ch] || chan_in[ch].disable_sw
        || !settled_r)
      else $error("pulse not started with its full length");
    chk_tuneout_exit: assert property
      (st_r[ch] == ST_DETECT && above && tick_r && cfg_r[ch].mode == MODE_PULSE
        && det_ms_r == 12'(`TUNEOUT_MS) |=> st_r[ch] == ST_IDLE
        && base_r == $past(chan_in[ch].dev))
      else $error("long pulse-mode detection was not tuned out");
    chk_detect_prompt: assert property
      (st_r[ch] == ST_IDLE && above |=> st_r[ch] == ST_DETECT)
      else $error("threshold crossing not detected at once");
    chk_release_prompt: assert property
      (st_r[ch] != ST_DETECT && call_ms_r == 8'h00 && !chan_in[ch].fault
        |=> !call_out[ch])
      else $error("call not released after the change ended");
    chk_baseline_follow: assert property
      (st_r[ch] == ST_IDLE && delta < 0 |=> base_r == $past(chan_in[ch].dev))
      else $error("baseline did not follow an inductance rise");
    chk_settle_gate: assert property
      (!settled_r && !chan_in[ch].fault |=> !call_out[ch])
      else $error("call issued before settling");
    chk_presence_hold: assert property
      (cfg_r[ch].mode == MODE_PRESENCE && st_r[ch] == ST_DETECT && above
        |=> $stable(base_r) && st_r[ch] == ST_DETECT)
      else $error("presence detection dropped while the vehicle stays");

    cov_pulse_call: cover property
      (cfg_r[ch].mode == MODE_PULSE && $rose(call_out[ch]));
    cov_presence_call: cover property
      (cfg_r[ch].mode == MODE_PRESENCE && st_r[ch] == ST_DETECT && call_out[ch]);
    cov_fault_call: cover property (chan_in[ch].fault ##1 call_out[ch]);
  end

  chk_tick_period: assert property
    (tick_r |-> $past(tick_cnt_r) == 32'(TICK_CYC - 1))
    else $error("millisecond tick out of period");

  // Read channel: configuration words and a status word
  logic [31:0] stat_word;
  logic [2:0]  rd_idx;
  always_comb
  begin
    stat_word                 = 32'h0000_0000;
    stat_word[NCH-1:0]        = call_out;
    stat_word[8+NCH-1:8]      = det_vec;
    for (int i = 0; i < NCH; i++)
      stat_word[16+i]         = chan_in[i].fault;
    stat_word[`STAT_SETTLED]  = settled_r;
    stat_word[`STAT_FULL]     = full_op;
  end
  assign rd_idx = s_axi_araddr[4:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == `STAT_ADDR)
          s_axi_rdata <= stat_word;
        else if (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0
                 && 32'(rd_idx) < NCH)
          s_axi_rdata <= {27'h000_0000, cfg_r[rd_idx]};
        else
          s_axi_rresp <= `RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- sim/ctl_unit_model.sv ----
// Behavioural controller-side input: counts call closures and issues a long reset pulse.
// Assumes the detector call outputs and the reset line share one 100 MHz clock.
`timescale 1ns/1ps
module ctl_unit_model #(
  parameter int NCH     = 2,
  parameter int RST_CYC = 1500
) (
  input  wire logic             aclk,
  input  wire logic             rst_req,
  input  wire logic [NCH-1:0]   call_out,
  output logic                  ctl_rstn,
  output logic [NCH-1:0][15:0]  pulse_cnt
);
  int                   rst_left = 0;
  logic [NCH-1:0]       call_q   = '0;
  logic [NCH-1:0][15:0] cnt_q    = '0;

  assign pulse_cnt = cnt_q;

  // Reset held low for 15 us, never a short glitch
  always @(posedge aclk)
  begin
    if (rst_req)
      rst_left <= RST_CYC;
    else if (rst_left > 0)
      rst_left <= rst_left - 1;
  end
  assign ctl_rstn = (rst_left == 0);

  // One count per rising call closure
  always @(posedge aclk)
  begin
    call_q <= call_out;
    for (int i = 0; i < NCH; i++)
      if (call_out[i] && !call_q[i])
        cnt_q[i] <= cnt_q[i] + 16'h0001;
  end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the loop detector timing block over AXI4-Lite and channel inputs.
// Assumes a 2 cycle millisecond tick so long timers fit a short run.
`timescale 1ns/1ps
`include "loop_det_defines.svh"
`define CMP(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import loop_det_pkg::*;
  localparam int NCH = 2;
  logic aclk = 0, tb_rstn = 0, rst_req = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, full_op;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  chan_in_t [NCH-1:0] chan_in = '0;
  logic [NCH-1:0] call_out;
  logic [NCH-1:0][1:0] freq_sel;
  logic [NCH-1:0][15:0] pulse_cnt;
  logic ctl_rstn;
  logic [15:0] p0, p1;
  int fail_count = 0, num_checks = 0, n;
  logic signed [15:0] thr [4];

  always #5 aclk = ~aclk;

  loop_det_timing #(.NCH(NCH), .TICK_CYC(2)) loop_det_timing_i (
    .aclk(aclk), .aresetn(tb_rstn & ctl_rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .chan_in(chan_in),
    .call_out(call_out), .freq_sel(freq_sel), .full_op(full_op));

  ctl_unit_model #(.NCH(NCH), .RST_CYC(1500)) ctl_unit_model_i (
    .aclk(aclk), .rst_req(rst_req), .call_out(call_out), .ctl_rstn(ctl_rstn),
    .pulse_cnt(pulse_cnt));

  // Verdict and end of run
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // Write one word, release each channel when taken, compare response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CMP(s_axi_bresp, er)
    end
  endtask

  // Read one word and compare masked data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CMP(s_axi_rresp, er)
      `CMP(s_axi_rdata & m, e)
    end
  endtask

  // Drive one channel's front-end inputs
  task automatic ch(input int i, input logic f, input logic ds, input logic signed [15:0] v);
    begin
      @(posedge aclk);
      chan_in[i] <= '{f, ds, v};
    end
  endtask

  // Count edges until the call reaches a level or the limit runs out
  task automatic wait_call(input int i, input logic v, input int mx, output int c);
    begin
      c = 0;
      while (call_out[i] !== v && c < mx)
      begin
        @(posedge aclk);
        c++;
      end
    end
  endtask

  // Watchdog
  initial
  begin
    #800_000;
    fail_count++;
    print_verdict();
  end

  // Test sequence
  initial
  begin
    thr = '{16'(`THR_LOW), 16'(`THR_MED), 16'(`THR_HIGH), 16'(`THR_HIGH)};
    repeat (4) @(posedge aclk);
    tb_rstn <= 1'b1;
    rd(8'h00, 32'h0000_0004, 32'h0000_001f, `RESP_OKAY);
    rd(8'h04, 32'h0000_0004, 32'h0000_001f, `RESP_OKAY);
    rd(8'h40, 32'h0000_0000, 32'hffff_ffff, `RESP_SLVERR);
    wr(8'h20, 32'h0000_0000, 4'hf, `RESP_SLVERR);
    ch(0, 1'b0, 1'b0, 16'sd400);
    wait_call(0, 1'b1, 1500, n);
    `CMP(n, 1500)
    ch(0, 1'b0, 1'b0, 16'sd0);
    repeat (600) @(posedge aclk);
    rd(8'h20, 32'h4000_0000, 32'hc000_0000, `RESP_OKAY);
    $display("test settle done");
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h00, 32'(s << 1), 4'hf, `RESP_OKAY);
      ch(0, 1'b0, 1'b0, thr[s] - 16'sd1);
      wait_call(0, 1'b1, 60, n);
      `CMP(n, 60)
      ch(0, 1'b0, 1'b0, 16'sd0);
      ch(0, 1'b0, 1'b0, thr[s]);
      wait_call(0, 1'b1, 60, n);
      `CMP(n < 40, 1'b1)
      ch(0, 1'b0, 1'b0, 16'sd0);
      wait_call(0, 1'b0, 400, n);
    end
    wr(8'h00, 32'h0000_0000, 4'hf, `RESP_OKAY);
    $display("test sensitivity done");
    ch(0, 1'b0, 1'b0, 16'sd320);
    wait_call(0, 1'b1, 60, n);
    repeat (20) @(posedge aclk);
    ch(0, 1'b0, 1'b0, 16'sd0);
    wait_call(0, 1'b0, 400, n);
    `CMP(n >= 227 && n <= 269, 1'b1)
    ch(0, 1'b0, 1'b0, 16'sd320);
    wait_call(0, 1'b1, 60, n);
    wait_call(0, 1'b0, 1000, n);
    `CMP(n, 1000)
    ch(0, 1'b0, 1'b0, 16'sd0);
    wait_call(0, 1'b0, 60, n);
    `CMP(n < 40, 1'b1)
    $display("test presence done");
    p0 = pulse_cnt[0];
    p1 = pulse_cnt[1];
    wr(8'h04, 32'h0000_0001, 4'hf, `RESP_OKAY);
    ch(1, 1'b0, 1'b0, 16'sd400);
    wait_call(1, 1'b1, 60, n);
    wait_call(1, 1'b0, 400, n);
    `CMP(n >= 200 && n <= 300, 1'b1)
    wait_call(1, 1'b1, 250, n);
    `CMP(n, 250)
    ch(1, 1'b0, 1'b0, 16'sd0);
    ch(1, 1'b0, 1'b0, 16'sd400);
    wait_call(1, 1'b1, 60, n);
    `CMP(n < 40, 1'b1)
    wait_call(1, 1'b0, 400, n);
    wait_call(1, 1'b1, 4500, n);
    `CMP(n, 4500)
    rd(8'h20, 32'h0000_0000, 32'h0000_0202, `RESP_OKAY);
    ch(1, 1'b0, 1'b0, 16'sd0);
    ch(1, 1'b0, 1'b0, 16'sd400);
    wait_call(1, 1'b1, 60, n);
    `CMP(n < 40, 1'b1)
    wait_call(1, 1'b0, 400, n);
    ch(1, 1'b0, 1'b0, 16'sd0);
    `CMP(pulse_cnt[1] - p1, 16'h0003)
    `CMP(pulse_cnt[0], p0)
    $display("test pulse done");
    ch(0, 1'b0, 1'b1, 16'sd400);
    wait_call(0, 1'b1, 100, n);
    `CMP(n, 100)
    ch(0, 1'b1, 1'b1, 16'sd400);
    wait_call(0, 1'b1, 5, n);
    `CMP(n < 4, 1'b1)
    rd(8'h20, 32'h0001_0001, 32'h0001_0001, `RESP_OKAY);
    wr(8'h00, 32'h0000_0001, 4'hf, `RESP_OKAY);
    ch(0, 1'b1, 1'b0, 16'sd0);
    wait_call(0, 1'b0, 1000, n);
    `CMP(n, 1000)
    ch(0, 1'b0, 1'b0, 16'sd0);
    wait_call(0, 1'b0, 5, n);
    `CMP(n < 4, 1'b1)
    $display("test fault done");
    wr(8'h00, 32'h0000_0018, 4'hf, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CMP(freq_sel, 4'h3)
    wr(8'h00, 32'h0000_0000, 4'h0, `RESP_OKAY);
    rd(8'h00, 32'h0000_0018, 32'h0000_001f, `RESP_OKAY);
    ch(0, 1'b0, 1'b0, -16'sd5000);
    ch(0, 1'b0, 1'b0, -16'sd4680);
    wait_call(0, 1'b1, 60, n);
    `CMP(n < 40, 1'b1)
    ch(0, 1'b0, 1'b0, -16'sd5000);
    wait_call(0, 1'b0, 400, n);
    `CMP(n < 400, 1'b1)
    $display("test config done");
    wr(8'h04, 32'h0000_0004, 4'hf, `RESP_OKAY);
    for (int k = 0; k < 25; k++)
    begin
      ch(1, 1'b0, 1'b0, 16'(k));
      wait_call(1, 1'b1, 2000, n);
      `CMP(n, 2000)
    end
    $display("test drift done");
    n = 0;
    while (full_op !== 1'b1 && n < 20000)
    begin
      @(posedge aclk);
      n++;
    end
    `CMP(full_op, 1'b1)
    rd(8'h20, 32'hc000_0000, 32'hc000_0000, `RESP_OKAY);
    @(posedge aclk);
    rst_req <= 1'b1;
    @(posedge aclk);
    rst_req <= 1'b0;
    repeat (1600) @(posedge aclk);
    `CMP(full_op, 1'b0)
    rd(8'h00, 32'h0000_0004, 32'h0000_001f, `RESP_OKAY);
    rd(8'h20, 32'h0000_0000, 32'hc000_0000, `RESP_OKAY);
    $display("test reset done");
    print_verdict();
  end
endmodule
